// ===== pkg/wpot_map.svh
// Purpose: constants for the wiper serial slave: address fields, command codes, timing
// Assumes: 200 MHz system clock
// Notes:   included by the package and by every design module
`ifndef WPOT_MAP_SVH
`define WPOT_MAP_SVH

// slave address byte layout
`define WPOT_ADDR_FIXED      4'h5
`define WPOT_ADDR_FIXED_HI   7
`define WPOT_ADDR_FIXED_LO   4
`define WPOT_ADDR_GRP_HI     3
`define WPOT_ADDR_GRP_LO     2
`define WPOT_ADDR_SEL_BIT    1
`define WPOT_ADDR_DIR_BIT    0
`define WPOT_DIR_WRITE       1'b0

// control byte layout
`define WPOT_CTRL_ZERO_BIT   7
`define WPOT_CTRL_XFER_BIT   6
`define WPOT_CTRL_STOR_BIT   5
`define WPOT_CTRL_LIVE_BIT   4
`define WPOT_CTRL_SEL_HI     3
`define WPOT_CTRL_SEL_LO     0
`define WPOT_REG_SEL         4'h1

// flag patterns {transfer, stored, live}
`define WPOT_FLAGS_LIVE      3'h1
`define WPOT_FLAGS_STORED    3'h2
`define WPOT_FLAGS_RECALL    3'h6
`define WPOT_FLAGS_SAVE      3'h5

// reset and initial values, bit counter limits
`define WPOT_LIVE_RST        8'h00
`define WPOT_NV_INIT         8'h80
`define WPOT_BYTE_LAST_BIT   4'h7
`define WPOT_ACK_BIT         4'h8

// timing
`define WPOT_CLK_NS          5
`define WPOT_POR_NS          10000
`define WPOT_POR_CYC         (`WPOT_POR_NS / `WPOT_CLK_NS)
`define WPOT_NV_PROG_NS      5000
`define WPOT_NV_PROG_CYC     (`WPOT_NV_PROG_NS / `WPOT_CLK_NS)
`define WPOT_CNT_W           12

// synchroniser width: scl, sda, bit toggle, bit value, address select
`define WPOT_SYNC_W          5

`endif

// ===== pkg/wpot_pkg.sv
// Purpose: shared types of the wiper serial slave
// Assumes: nothing beyond the map header
// Notes:   states and decoded commands
`include "wpot_map.svh"

package wpot_pkg;

    typedef enum logic [2:0] {
        WPOT_ST_INIT,
        WPOT_ST_IDLE,
        WPOT_ST_ADDR,
        WPOT_ST_CTRL,
        WPOT_ST_DATA,
        WPOT_ST_SKIP
    } wpot_state_e;

    typedef enum logic [2:0] {
        WPOT_CMD_NONE,
        WPOT_CMD_LIVE,
        WPOT_CMD_STORED,
        WPOT_CMD_RECALL,
        WPOT_CMD_SAVE
    } wpot_cmd_e;

endpackage : wpot_pkg

// ===== src/wpot_sync.sv
// Purpose: two-flop synchroniser for pin and link-domain levels
// Assumes: each bit changes slowly relative to clk_i
// Notes:   only the second flop is visible outside
`include "wpot_map.svh"

module wpot_sync
    import wpot_pkg::*;
(
    // clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    rst_n_i,
    // levels
    input  wire logic [`WPOT_SYNC_W-1:0] async_i,
    output logic      [`WPOT_SYNC_W-1:0] sync_o
);

    logic [`WPOT_SYNC_W-1:0] meta_ff;
    logic [`WPOT_SYNC_W-1:0] sync_ff;

    // idle bus levels are high; resetting to ones avoids a false edge
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_ff <= '1;
            sync_ff <= '1;
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;

endmodule // wpot_sync

// ===== src/wpot_nvstore.sv
// Purpose: single 8-bit nonvolatile wiper store with a programming time
// Assumes: prog_i is a one-cycle pulse from the clk_i domain
// Notes:   the stored value survives rst_n_i, like a retained cell
`include "wpot_map.svh"

module wpot_nvstore
    import wpot_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // programming request
    input  wire logic       prog_i,
    input  wire logic [7:0] prog_data_i,
    // state
    output logic      [7:0] stored_o,
    output logic            busy_o
);

    logic [7:0]             stored_ff = `WPOT_NV_INIT;
    logic [7:0]             hold_ff;
    logic [`WPOT_CNT_W-1:0] cnt_ff;
    logic                   busy_ff;
    logic                   done;

    assign done = busy_ff && (cnt_ff == `WPOT_CNT_W'(`WPOT_NV_PROG_CYC - 1));

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_ff <= 1'b0;
            cnt_ff  <= '0;
            hold_ff <= `WPOT_LIVE_RST;
        end else if (prog_i && !busy_ff) begin
            busy_ff <= 1'b1;
            cnt_ff  <= '0;
            hold_ff <= prog_data_i;
        end else if (done) begin
            busy_ff <= 1'b0;
        end else if (busy_ff) begin
            cnt_ff  <= cnt_ff + `WPOT_CNT_W'(1);
        end
    end

    // no reset: the cell keeps its content across power loss
    always_ff @(posedge clk_i) begin
        if (done) begin
            stored_ff <= hold_ff;
        end
    end

    assign stored_o = stored_ff;
    assign busy_o   = busy_ff;

endmodule // wpot_nvstore

// ===== src/wpot_top.sv
// Purpose: write-only two-wire slave steering live and stored wiper registers
// Assumes: scl_i is the master's bus clock; it stops between frames
// Notes:   bit capture runs on scl_i, framing and decode on clk_i
//
// Contract
// - answer only a 7-bit address followed by a direction bit
// - top four address bits must be 0101, otherwise ignore
// - address bits two and one come from a build-time group constant
// - address LSB equals the sampled address select pin level
// - pull SDA low across the ninth clock of each accepted byte
// - first byte after address is control, later bytes are data
// - first data byte goes to the register the control byte chose
// - control byte MSB first: zero, flags, select 0001; four flag patterns
// - live write loads the live register, wiper follows at once
// - stored write programs the stored register, wiper unchanged
// - recall copies stored into live, data byte ignored
// - save copies live into stored, data byte ignored
// - stored copy is one 8-bit register kept across power loss
// - stored register initially holds midscale
// - at power-up copy stored into live
// - power-up recall finishes within 10 us
// - drop to standby whenever no transaction is in progress; standby also waits for power-up recall and nonvolatile programming
// - start is SDA fall with SCL high, stop SDA rise with SCL high
// - live register is lost at power removal, only stored remains
`include "wpot_map.svh"

module wpot_top
    import wpot_pkg::*;
#(
    parameter logic [1:0] ADDR_GROUP = 2'h0
) (
    // system clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // two-wire bus
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    // address strap
    input  wire logic       addr_select_pin_i,
    // wiper and status
    output logic [7:0]      wiper_o,
    output logic            standby_o,
    output logic            nv_busy_o
);

    // ---------------- link domain: bit capture on scl_i ----------------
    logic bit_val_ff;
    logic bit_tgl_ff;

    // data is stable while scl is high; a toggle marks each captured bit
    always_ff @(posedge scl_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bit_val_ff <= 1'b1;
            bit_tgl_ff <= 1'b1;  // matches the synchroniser's reset level: no false bit
        end else begin
            bit_val_ff <= sda_i;
            bit_tgl_ff <= ~bit_tgl_ff;
        end
    end

    // ---------------- crossing into clk_i ----------------
    logic [`WPOT_SYNC_W-1:0] sync_in;
    logic [`WPOT_SYNC_W-1:0] sync_out;
    logic                    scl_s;
    logic                    sda_s;
    logic                    tgl_s;
    logic                    val_s;
    logic                    asel_s;

    assign sync_in = {addr_select_pin_i, bit_val_ff, bit_tgl_ff, sda_i, scl_i};

    wpot_sync u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .async_i (sync_in),
        .sync_o  (sync_out)
    );

    assign scl_s  = sync_out[0];
    assign sda_s  = sync_out[1];
    assign tgl_s  = sync_out[2];
    assign val_s  = sync_out[3];
    assign asel_s = sync_out[4];

    // ---------------- bus conditions ----------------
    logic scl_q_ff;
    logic sda_q_ff;
    logic tgl_q_ff;
    logic bit_evt_ff;
    logic start_det;
    logic stop_det;
    logic scl_fall;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_q_ff   <= 1'b1;
            sda_q_ff   <= 1'b1;
            tgl_q_ff   <= 1'b1;
            bit_evt_ff <= 1'b0;
        end else begin
            scl_q_ff   <= scl_s;
            sda_q_ff   <= sda_s;
            tgl_q_ff   <= tgl_s;
            // one cycle late so the value bit has surely settled too
            bit_evt_ff <= tgl_s ^ tgl_q_ff;
        end
    end

    assign start_det = scl_s && scl_q_ff && sda_q_ff && !sda_s;
    assign stop_det  = scl_s && scl_q_ff && !sda_q_ff && sda_s;
    assign scl_fall  = scl_q_ff && !scl_s;

    // ---------------- decode helpers ----------------
    function automatic logic addr_match(input logic [7:0] b, input logic sel);
        addr_match = (b[`WPOT_ADDR_FIXED_HI:`WPOT_ADDR_FIXED_LO] == `WPOT_ADDR_FIXED)
                  && (b[`WPOT_ADDR_GRP_HI:`WPOT_ADDR_GRP_LO] == ADDR_GROUP)
                  && (b[`WPOT_ADDR_SEL_BIT] == sel)
                  && (b[`WPOT_ADDR_DIR_BIT] == `WPOT_DIR_WRITE);
    endfunction

    function automatic wpot_cmd_e cmd_decode(input logic [7:0] b);
        logic [2:0] flags;
        flags = {b[`WPOT_CTRL_XFER_BIT], b[`WPOT_CTRL_STOR_BIT], b[`WPOT_CTRL_LIVE_BIT]};
        cmd_decode = WPOT_CMD_NONE;
        if (!b[`WPOT_CTRL_ZERO_BIT] && b[`WPOT_CTRL_SEL_HI:`WPOT_CTRL_SEL_LO] == `WPOT_REG_SEL)
        begin
            case (flags)
                `WPOT_FLAGS_LIVE:   cmd_decode = WPOT_CMD_LIVE;
                `WPOT_FLAGS_STORED: cmd_decode = WPOT_CMD_STORED;
                `WPOT_FLAGS_RECALL: cmd_decode = WPOT_CMD_RECALL;
                `WPOT_FLAGS_SAVE:   cmd_decode = WPOT_CMD_SAVE;
                default:            cmd_decode = WPOT_CMD_NONE;
            endcase
        end
    endfunction

    // ---------------- byte assembly ----------------
    wpot_state_e            state_ff;
    logic [3:0]             bit_cnt_ff;
    logic [7:0]             shift_ff;
    logic                   byte_done;
    logic [7:0]             byte_val;
    logic                   in_frame;

    assign in_frame  = (state_ff == WPOT_ST_ADDR) || (state_ff == WPOT_ST_CTRL)
                    || (state_ff == WPOT_ST_DATA) || (state_ff == WPOT_ST_SKIP);
    assign byte_val  = {shift_ff[6:0], val_s};
    assign byte_done = in_frame && bit_evt_ff && (bit_cnt_ff == `WPOT_BYTE_LAST_BIT);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bit_cnt_ff <= '0;
            shift_ff   <= '0;
        end else if (start_det || stop_det) begin
            bit_cnt_ff <= '0;
        end else if (in_frame && bit_evt_ff) begin
            if (bit_cnt_ff == `WPOT_ACK_BIT) begin
                // ninth bit is the acknowledge slot, nothing to keep
                bit_cnt_ff <= '0;
            end else begin
                shift_ff   <= byte_val;
                bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end
        end
    end

    // ---------------- power-up recall timer ----------------
    logic [`WPOT_CNT_W-1:0] por_cnt_ff;
    logic                   por_done;

    assign por_done = (state_ff == WPOT_ST_INIT)
                   && (por_cnt_ff == `WPOT_CNT_W'(`WPOT_POR_CYC - 1));

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            por_cnt_ff <= '0;
        end else if (state_ff == WPOT_ST_INIT) begin
            por_cnt_ff <= por_cnt_ff + `WPOT_CNT_W'(1);
        end
    end

    // ---------------- frame state ----------------
    logic      asel_ff;
    logic      data_seen_ff;
    wpot_cmd_e cmd_ff;
    logic      accept;
    logic      data_act;

    // every byte of an addressed write is acknowledged, extra data included
    assign accept   = byte_done && ((state_ff == WPOT_ST_ADDR) ? addr_match(byte_val, asel_ff)
                                  : (state_ff != WPOT_ST_SKIP));
    assign data_act = byte_done && (state_ff == WPOT_ST_DATA) && !data_seen_ff;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff <= WPOT_ST_INIT;
        end else begin
            case (state_ff)
                WPOT_ST_INIT: begin
                    // bus traffic during the recall window is not answered
                    if (por_done) begin
                        state_ff <= WPOT_ST_IDLE;
                    end
                end
                default: begin
                    if (stop_det) begin
                        state_ff <= WPOT_ST_IDLE;
                    end else if (start_det) begin
                        state_ff <= WPOT_ST_ADDR;
                    end else if (byte_done) begin
                        case (state_ff)
                            WPOT_ST_ADDR: state_ff <= accept ? WPOT_ST_CTRL : WPOT_ST_SKIP;
                            WPOT_ST_CTRL: state_ff <= WPOT_ST_DATA;
                            default:      state_ff <= state_ff;
                        endcase
                    end
                end
            endcase
        end
    end

    // strap level is taken at each start, not under reset
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            asel_ff <= 1'b0;
        end else if (start_det) begin
            asel_ff <= asel_s;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmd_ff       <= WPOT_CMD_NONE;
            data_seen_ff <= 1'b0;
        end else if (start_det) begin
            cmd_ff       <= WPOT_CMD_NONE;
            data_seen_ff <= 1'b0;
        end else if (byte_done && state_ff == WPOT_ST_CTRL) begin
            cmd_ff       <= cmd_decode(byte_val);
        end else if (data_act) begin
            data_seen_ff <= 1'b1;
        end
    end

    // ---------------- acknowledge drive ----------------
    logic ack_pend_ff;
    logic sda_oe_ff;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_pend_ff <= 1'b0;
            sda_oe_ff   <= 1'b0;
        end else if (start_det || stop_det) begin
            ack_pend_ff <= 1'b0;
            sda_oe_ff   <= 1'b0;
        end else if (accept) begin
            ack_pend_ff <= 1'b1;
        end else if (scl_fall && ack_pend_ff) begin
            // low from the eighth falling edge through the ninth high phase
            ack_pend_ff <= 1'b0;
            sda_oe_ff   <= 1'b1;
        end else if (scl_fall && sda_oe_ff) begin
            sda_oe_ff   <= 1'b0;
        end
    end

    // ---------------- wiper registers ----------------
    logic [7:0] live_wiper_setting_ff;
    logic [7:0] stored_val;
    logic       nv_busy;

    // volatile: cleared by reset, then loaded from the stored copy
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            live_wiper_setting_ff <= `WPOT_LIVE_RST;
        end else if (por_done) begin
            live_wiper_setting_ff <= stored_val;
        end else if (data_act && cmd_ff == WPOT_CMD_LIVE) begin
            live_wiper_setting_ff <= byte_val;
        end else if (data_act && cmd_ff == WPOT_CMD_RECALL) begin
            live_wiper_setting_ff <= stored_val;
        end
    end

    // ---------------- deferred nonvolatile programming ----------------
    logic       nv_pend_ff;
    logic       nv_save_ff;
    logic [7:0] nv_data_ff;
    logic       nv_prog;
    logic [7:0] nv_prog_data;

    // the cell is only touched once the bus is idle and the store is free
    assign nv_prog      = nv_pend_ff && (state_ff == WPOT_ST_IDLE) && !nv_busy;
    assign nv_prog_data = nv_save_ff ? live_wiper_setting_ff : nv_data_ff;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            nv_pend_ff <= 1'b0;
            nv_save_ff <= 1'b0;
            nv_data_ff <= `WPOT_LIVE_RST;
        end else if (data_act && cmd_ff == WPOT_CMD_STORED) begin
            nv_pend_ff <= 1'b1;
            nv_save_ff <= 1'b0;
            nv_data_ff <= byte_val;
        end else if (data_act && cmd_ff == WPOT_CMD_SAVE) begin
            nv_pend_ff <= 1'b1;
            nv_save_ff <= 1'b1;
        end else if (nv_prog) begin
            nv_pend_ff <= 1'b0;
        end
    end

    wpot_nvstore u_nvstore (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .prog_i      (nv_prog),
        .prog_data_i (nv_prog_data),
        .stored_o    (stored_val),
        .busy_o      (nv_busy)
    );

    // ---------------- outputs ----------------
    logic standby_ff;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            standby_ff <= 1'b0;
        end else begin
            standby_ff <= (state_ff == WPOT_ST_IDLE) && !nv_pend_ff && !nv_busy;
        end
    end

    // open drain: only ever pulls low
    assign sda_o     = 1'b0;
    assign sda_oe_o  = sda_oe_ff;
    assign wiper_o   = live_wiper_setting_ff;
    assign standby_o = standby_ff;
    assign nv_busy_o = nv_busy;

endmodule // wpot_top

// ===== dv/wpot_top_assertions.sv
// Purpose: port-level checks of the wiper serial slave
// Assumes: one clk_i domain; bus lines sampled as plain levels
// Notes:   bound to every wpot_top instance
`include "wpot_map.svh"

module wpot_checker
    import wpot_pkg::*;
#(
    parameter logic [1:0] ADDR_GROUP = 2'h0
) (
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    input wire logic       scl_i,
    input wire logic       sda_i,
    input wire logic       sda_o,
    input wire logic       sda_oe_o,
    input wire logic       addr_select_pin_i,
    input wire logic [7:0] wiper_o,
    input wire logic       standby_o,
    input wire logic       nv_busy_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [11:0] por_cnt_ff;
    logic [11:0] busy_cnt_ff;

    // saturates so a long run never wraps back into the init window
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            por_cnt_ff <= 12'h000;
        end else if (por_cnt_ff != 12'hfff) begin
            por_cnt_ff <= por_cnt_ff + 12'h001;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_cnt_ff <= 12'h000;
        end else begin
            busy_cnt_ff <= nv_busy_o ? busy_cnt_ff + 12'h001 : 12'h000;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_open_drain_low: assert property (sda_o == 1'b0)
        else $error("data output not held low");
    a_ack_starts_low: assert property ($rose(sda_oe_o) |-> !scl_i)
        else $error("ack raised while clock high");
    a_ack_spans_high: assert property (sda_oe_o && $rose(scl_i) |-> sda_oe_o[*5])
        else $error("ack dropped during clock high");
    a_ack_one_period: assert property ($rose(sda_oe_o) |-> sda_oe_o[*8] ##[1:12] !sda_oe_o)
        else $error("ack length wrong");
    a_ack_ends_low: assert property ($fell(sda_oe_o) |-> !scl_i)
        else $error("ack released while clock high");
    a_idle_no_ack: assert property (standby_o |-> !sda_oe_o && !nv_busy_o)
        else $error("standby while active");
    a_prog_after_stop: assert property ($rose(nv_busy_o) |-> scl_i && sda_i)
        else $error("programming began on a busy bus");
    a_prog_length: assert property ($fell(nv_busy_o) |-> busy_cnt_ff == `WPOT_NV_PROG_CYC)
        else $error("programming time wrong");
    a_init_quiet: assert property (por_cnt_ff < `WPOT_POR_CYC |-> wiper_o == 8'h00 && !sda_oe_o)
        else $error("activity during power-up recall");
    a_init_done: assert property (por_cnt_ff == `WPOT_POR_CYC + 3 |-> standby_o)
        else $error("power-up recall too slow");
    a_idle_wiper_stable: assert property (standby_o && $past(standby_o) |-> $stable(wiper_o))
        else $error("wiper moved while idle");

    c_ack: cover property ($rose(sda_oe_o));
    c_prog: cover property ($rose(nv_busy_o));
    c_wiper_move: cover property (!standby_o && $changed(wiper_o));
endmodule // wpot_checker

bind wpot_top wpot_checker #(.ADDR_GROUP(ADDR_GROUP)) u_wpot_checker (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .addr_select_pin_i(addr_select_pin_i), .wiper_o(wiper_o),
    .standby_o(standby_o), .nv_busy_o(nv_busy_o)
);

// ===== dv/wpot_master.sv
// Purpose: behavioural two-wire bus master for the wiper slave
// Assumes: 64 ns bus clock, pull-up on both lines
// Notes:   clock stands high between frames; ack_bits high = acked
module wpot_master (
    // bus lines
    output logic      scl_o,
    output logic      sda_o,
    input  wire logic sda_i
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [3:0] ack_bits;

    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
        ack_bits = 4'h0;
    end

    // n bytes after start: address, control, then data bytes d and e
    task automatic frame(input logic [7:0] a, c, d, e, input int n);
        logic [7:0] b;
        ack_bits = 4'h0;
        // odd offset keeps bus edges off the system clock edges
        #16.3 sda_o = 1'b0;
        #32 scl_o = 1'b0;
        for (int i = 0; i < n; i++) begin
            b = (i == 0) ? a : (i == 1) ? c : (i == 2) ? d : e;
            for (int k = 7; k >= 0; k--) begin
                #16 sda_o = b[k];
                #16 scl_o = 1'b1;
                #32 scl_o = 1'b0;
            end
            #16 sda_o = 1'b1;
            #16 scl_o = 1'b1;
            #16 ack_bits[i] = ~sda_i;
            #16 scl_o = 1'b0;
        end
        #16 sda_o = 1'b0;
        #16 scl_o = 1'b1;
        #16 sda_o = 1'b1;
        #32;
    endtask
endmodule // wpot_master

// ===== dv/test_wiper_serial_slave.sv
// Purpose: self-checking bench of the wiper serial slave
// Assumes: single slave on the bus, so its address is unique
// Notes:   seeded lfsr picks data and the strap level
`include "wpot_map.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fails++; \
    $display("mismatch at %0t got %h expected %h", $time, a, e); end end

module test_wiper_serial_slave;
    timeunit 1ns;
    timeprecision 100ps;
    import wpot_pkg::*;

    localparam logic [1:0] GRP = 2'h2;
    logic       clk_i, rst_n_i, pin, scl, sda_m, sda_o, sda_oe_o, standby_o, nv_busy_o;
    logic [7:0] wiper_o, d1, d2, d3;
    logic [31:0] seed;
    int         fails, num_checks, cycles;
    // pull-up: low only if someone pulls
    wire        sda = sda_m & ~(sda_oe_o & ~sda_o);

    wpot_top #(.ADDR_GROUP(GRP)) u_wpot_top (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_o(sda_oe_o), .addr_select_pin_i(pin), .wiper_o(wiper_o),
        .standby_o(standby_o), .nv_busy_o(nv_busy_o));
    wpot_master u_wpot_master (.scl_o(scl), .sda_o(sda_m), .sda_i(sda));

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] adr(input logic a0);
        return {`WPOT_ADDR_FIXED, GRP, a0, `WPOT_DIR_WRITE};
    endfunction
    function automatic logic [7:0] ctl(input logic [2:0] f);
        return {1'b0, f, `WPOT_REG_SEL};
    endfunction

    task automatic rnd(output logic [7:0] v);
        seed = lfsr(seed);
        v = seed[7:0];
    endtask
    // one frame, then wait until the slave is idle again
    task automatic send(input logic [7:0] a, c, d, input int n, input logic [3:0] acks);
        logic [7:0] e;
        logic       nv;
        rnd(e);
        u_wpot_master.frame(a, c, d, e, n);
        `CHK(u_wpot_master.ack_bits, acks)
        // a stored write or save to this slave programs right after the stop
        nv = (n > 2) && (a == adr(pin))
          && (c == ctl(`WPOT_FLAGS_STORED) || c == ctl(`WPOT_FLAGS_SAVE));
        `CHK(nv_busy_o, nv)
        for (int i = 0; i < 3000 && standby_o !== 1'b1; i++) @(posedge clk_i);
        `CHK(standby_o, 1'b1)
    endtask
    task automatic do_reset(input logic [7:0] exp);
        @(posedge clk_i) rst_n_i <= 1'b0;
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (1990) @(posedge clk_i);
        `CHK(wiper_o, 8'h00)
        repeat (15) @(posedge clk_i);
        `CHK(wiper_o, exp)
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // whole run is near 20000 cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 60000) begin
            fails++;
            stop_test();
        end
    end

    initial begin
        rst_n_i = 1'b0;
        pin = 1'b0;
        seed = 32'hbdf99547;
        do_reset(`WPOT_NV_INIT);
        for (int i = 0; i < 16; i++) begin
            if (i != 5) send({i[3:0], GRP, pin, 1'b0}, ctl(`WPOT_FLAGS_LIVE), 8'h3c, 3, 4'h0);
        end
        for (int g = 0; g < 4; g++) begin
            if (g != GRP) send({4'h5, g[1:0], pin, 1'b0}, ctl(`WPOT_FLAGS_LIVE), 8'h3c, 3, 4'h0);
        end
        send(adr(pin) | 8'h01, ctl(`WPOT_FLAGS_LIVE), 8'h3c, 3, 4'h0);
        `CHK(wiper_o, `WPOT_NV_INIT)
        for (int i = 0; i < 4; i++) begin
            rnd(d1);
            @(posedge clk_i) pin <= seed[9];
            @(posedge clk_i);
            send(adr(~pin), ctl(`WPOT_FLAGS_LIVE), d1, 3, 4'h0);
            send(adr(pin), ctl(`WPOT_FLAGS_LIVE), d1, 4, 4'hf);
            `CHK(wiper_o, d1)
        end
        send(adr(pin), 8'h00, 8'h00, 1, 4'h1);
        send(adr(pin), ctl(3'h3), 8'h11, 3, 4'h7);
        send(adr(pin), {1'b0, `WPOT_FLAGS_LIVE, 4'h2}, 8'h22, 3, 4'h7);
        `CHK(wiper_o, d1)
        rnd(d2);
        send(adr(pin), ctl(`WPOT_FLAGS_STORED), d2, 3, 4'h7);
        `CHK(wiper_o, d1)
        send(adr(pin), ctl(`WPOT_FLAGS_RECALL), ~d2, 3, 4'h7);
        `CHK(wiper_o, d2)
        rnd(d3);
        send(adr(pin), ctl(`WPOT_FLAGS_LIVE), d3, 3, 4'h7);
        send(adr(pin), ctl(`WPOT_FLAGS_SAVE), ~d3, 3, 4'h7);
        send(adr(pin), ctl(`WPOT_FLAGS_LIVE), ~d3, 3, 4'h7);
        `CHK(wiper_o, ~d3)
        send(adr(pin), ctl(`WPOT_FLAGS_RECALL), d2, 3, 4'h7);
        `CHK(wiper_o, d3)
        do_reset(d3);
        send(adr(pin), ctl(`WPOT_FLAGS_RECALL), 8'h00, 3, 4'h7);
        `CHK(wiper_o, d3)
        stop_test();
    end
endmodule // test_wiper_serial_slave
